//--- bench/dbtr_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
module dbtr_ctrl_model
(
	input wire logic core_clk,
	output logic dram_ck,
	output logic cke,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [1:0] ba,
	output logic a10,
	output logic [1:0] dm
);
	// Free running, phase unrelated to the core clock
	initial
	begin
		dram_ck = 1'b0;
		#137;
		forever #400 dram_ck = ~dram_ck;
	end
	initial
	begin
		cke = 1'b1;
		{cs_n, ras_n, cas_n, we_n} = 4'h7;
		ba = 2'h0;
		a10 = 1'b0;
		dm = 2'h3;
	end
	// Pins move near the falling link edge, so they are settled at the rising one.
	// Each command is followed by one NOP cycle; the mask stays put through the write beats.
	task automatic issue(input logic c, input logic [3:0] p, input logic [1:0] b,
		input logic a, input logic [1:0] m);
		@(negedge dram_ck);
		@(posedge core_clk);
		cke <= c;
		{cs_n, ras_n, cas_n, we_n} <= p;
		ba <= b;
		a10 <= a;
		dm <= m;
		@(negedge dram_ck);
		@(posedge core_clk);
		{cs_n, ras_n, cas_n, we_n} <= 4'h7;
	endtask
endmodule
`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import dbtr_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] ra = 4'h0;
	logic [15:0] wd = 16'h0;
	logic rw = 1'b0;
	logic rr = 1'b0;
	wire logic ck, cke, cs_n, ras_n, cas_n, we_n, a10, ir, rdv, dll, ib, err;
	wire logic [1:0] ba, dm, be;
	wire logic [3:0] bo, ip;
	wire logic [12:0] row;
	wire logic [15:0] rd;
	int ticks = 0;
	int pre_t = 0;
	int refs = 0;
	int t0 = 0;
	int bad_count = 0;
	int comparisons = 0;
	logic [15:0] v;
	dbtr_ctrl_model dbtr_ctrl_model_inst (.core_clk(clk), .dram_ck(ck), .cke(cke),
		.cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .a10(a10), .dm(dm));
	dbtr_top dbtr_top_inst (.CORE_CLK(clk), .RESET_N(rst_n), .CE(1'b1), .DRAM_CK(ck),
		.CKE(cke), .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .BA(ba),
		.A10(a10), .DM(dm), .REG_ADDR(ra), .REG_WDATA(wd), .REG_WR(rw), .REG_RD(rr),
		.REG_RDATA(rd), .BANK_OPEN(bo), .INT_PRECHARGE(ip), .INT_REFRESH(ir),
		.REF_ROW(row), .RD_DATA_VALID(rdv), .WR_BYTE_EN(be), .DLL_EN(dll),
		.INBUF_EN(ib), .PROTO_ERR(err));
	always #50 clk = ~clk;
	always @(posedge ck) ticks++;
	always @(posedge clk)
	begin
		if ((|ip) === 1'b1)
			pre_t = ticks;
		if (ir === 1'b1)
			refs++;
	end
	task automatic check(input logic [15:0] s, input logic [15:0] e);
		comparisons++;
		if (s !== e)
		begin
			bad_count++;
			$display("[ERR] %0t saw %h expected %h", $time, s, e);
		end
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		ra <= a;
		wd <= d;
		rw <= 1'b1;
		@(posedge clk);
		rw <= 1'b0;
	endtask
	task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		ra <= a;
		rr <= 1'b1;
		@(posedge clk);
		rr <= 1'b0;
		#1;
		d = rd;
	endtask
	task automatic cmd(input logic c, input logic [3:0] p, input logic [1:0] b,
		input logic a, input logic [1:0] m);
		dbtr_ctrl_model_inst.issue(c, p, b, a, m);
		t0 = ticks;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge ck);
		#1;
	endtask
	// Waits for read valid (sel 0) or a write byte enable (sel 1), returns ticks taken
	task automatic lat(input int sel, output logic [15:0] l);
		int n;
		n = 0;
		while (((sel == 0) ? rdv : (|be)) !== 1'b1 && n < 300)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		l = 16'(ticks - t0);
	endtask
	task automatic high_len(output logic [15:0] l);
		l = 16'h0;
		while (rdv === 1'b1 && l < 16'h0100)
		begin
			@(posedge clk);
			#1;
			l++;
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		#1_000_000;
		bad_count++;
		conclude;
	end
	initial
	begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		check({14'h0, dll, ib}, 16'h0003);
		reg_rd(REG_CFG, v);
		check(v, 16'h0018);
		reg_rd(REG_STAT, v);
		check(v, 16'h0040);
		reg_rd(4'h2, v);
		check(v, 16'h0000);
		$display("test reset done");
		cmd(1'b1, CMD_REF, 2'h0, 1'b0, 2'h3);
		idle(2);
		check(16'(refs), 16'h0001);
		reg_rd(REG_ROW, v);
		check(v, 16'h0001);
		check({15'h0, err}, 16'h0000);
		$display("test refresh done");
		// AL 1, CL 3: read latency 4, write latency 3
		reg_wr(REG_CFG, 16'h0019);
		cmd(1'b1, CMD_ACT, 2'h0, 1'b0, 2'h3);
		cmd(1'b1, CMD_RD, 2'h0, 1'b1, 2'h0);
		lat(0, v);
		check(v, 16'h0004);
		check({14'h0, be}, 16'h0000);
		high_len(v);
		check(v, 16'h0010);
		check(16'(pre_t - t0), 16'h0003);
		check({12'h0, bo}, 16'h0000);
		$display("test read auto precharge BL4 done");
		reg_wr(REG_CFG, 16'h0099);
		cmd(1'b1, CMD_ACT, 2'h2, 1'b0, 2'h3);
		cmd(1'b1, CMD_RD, 2'h2, 1'b1, 2'h3);
		lat(0, v);
		check(v, 16'h0004);
		high_len(v);
		check(v, 16'h0020);
		check(16'(pre_t - t0), 16'h0005);
		check({15'h0, err}, 16'h0000);
		$display("test read auto precharge BL8 done");
		cmd(1'b1, CMD_ACT, 2'h3, 1'b0, 2'h3);
		cmd(1'b1, CMD_ACT, 2'h1, 1'b0, 2'h3);
		cmd(1'b1, CMD_WR, 2'h1, 1'b0, 2'h1);
		lat(1, v);
		check(v, 16'h0003);
		check({14'h0, be}, 16'h0002);
		check({12'h0, bo}, 16'h000A);
		idle(6);
		cmd(1'b1, CMD_PRE, 2'h0, 1'b1, 2'h3);
		idle(2);
		check({12'h0, bo}, 16'h0000);
		$display("test write and precharge all done");
		cmd(1'b1, CMD_ACT, 2'h0, 1'b0, 2'h3);
		cmd(1'b1, CMD_RD, 2'h0, 1'b0, 2'h3);
		cmd(1'b1, CMD_RD, 2'h0, 1'b0, 2'h3);
		check({15'h0, err}, 16'h0000);
		cmd(1'b1, CMD_PRE, 2'h0, 1'b0, 2'h3);
		check({15'h0, err}, 16'h0001);
		$display("test read interrupt and precharge spacing done");
		reg_wr(REG_ERRCLR, 16'h0001);
		cmd(1'b1, CMD_ACT, 2'h0, 1'b0, 2'h3);
		cmd(1'b1, CMD_REF, 2'h0, 1'b0, 2'h3);
		idle(2);
		check({15'h0, err}, 16'h0001);
		reg_wr(REG_ERRCLR, 16'h0001);
		cmd(1'b1, CMD_PRE, 2'h0, 1'b1, 2'h3);
		idle(3);
		reg_rd(REG_STAT, v);
		check(v & 16'h0080, 16'h0000);
		$display("test refresh with open bank done");
		v = 16'(refs);
		cmd(1'b0, CMD_REF, 2'h0, 1'b0, 2'h3);
		idle(2);
		check({14'h0, dll, ib}, 16'h0000);
		check(16'(refs) - v, 16'h0001);
		reg_rd(REG_STAT, v);
		check(v & 16'h0030, 16'h0010);
		idle(4);
		cmd(1'b1, CMD_NOP, 2'h0, 1'b0, 2'h3);
		idle(4);
		check({14'h0, dll, ib}, 16'h0003);
		check({15'h0, err}, 16'h0000);
		cmd(1'b1, CMD_REF, 2'h0, 1'b0, 2'h3);
		idle(2);
		$display("test self refresh done");
		reg_wr(REG_CFG, 16'h0199);
		cmd(1'b1, CMD_ACT, 2'h0, 1'b0, 2'h3);
		cmd(1'b0, CMD_NOP, 2'h0, 1'b0, 2'h3);
		idle(2);
		check({14'h0, dll, ib}, 16'h0002);
		idle(4);
		cmd(1'b1, CMD_NOP, 2'h0, 1'b0, 2'h3);
		idle(3);
		cmd(1'b1, CMD_PRE, 2'h0, 1'b1, 2'h3);
		idle(2);
		cmd(1'b0, CMD_NOP, 2'h0, 1'b0, 2'h3);
		idle(2);
		check({14'h0, dll, ib}, 16'h0000);
		idle(4);
		cmd(1'b1, CMD_NOP, 2'h0, 1'b0, 2'h3);
		idle(3);
		check({13'h0, dll, ib, err}, 16'h0006);
		$display("test power down done");
		conclude;
	end
endmodule
`default_nettype wire

//--- rtl/dbtr_bank.sv
`timescale 1ns/1ns
`default_nettype none
module dbtr_bank
#(
	parameter int W = 8
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic en,
	input wire logic act,
	input wire logic rd,
	input wire logic wr,
	input wire logic ap,
	input wire logic pre,
	input wire logic [W-1:0] rd_blk,
	input wire logic [W-1:0] rd_apd,
	input wire logic [W-1:0] wr_blk,
	output logic is_open,
	output logic fire,
	output logic act_ok,
	output logic pre_ok
);
	import dbtr_pkg::*;
	logic open_q, open_d, pend_q, pend_d;
	logic [W-1:0] ras_q, ras_d, rp_q, rp_d, blk_q, blk_d, apc_q, apc_d;
	if (W < 8)
	begin : g_chk
		$error("dbtr_bank: counter width below 8");
	end
	function automatic logic [W-1:0] dec(input logic [W-1:0] v);
		return (v != '0) ? v - W'(1) : v;
	endfunction
	// Auto precharge only when the delay, tRAS and tRTP or tWR are all met
	// A count of one has run out at this tick, so the action may happen now
	assign fire = en && pend_q && apc_q <= W'(1)
		&& ras_q <= W'(1) && blk_q <= W'(1); // [RQ8] [RQ11]
	assign is_open = open_q;
	assign pre_ok = ras_q <= W'(1) && blk_q <= W'(1); // [RQ3] [RQ4] [RQ6]
	// tRC is covered since tRP starts after tRAS, except on an early precharge, which top flags as an error
	assign act_ok = !open_q && !pend_q && rp_q <= W'(1); // [RQ10]
	always_comb
	begin
		open_d = open_q;
		pend_d = pend_q;
		ras_d = ras_q;
		rp_d = rp_q;
		blk_d = blk_q;
		apc_d = apc_q;
		if (en)
		begin
			ras_d = dec(ras_q);
			rp_d = dec(rp_q);
			blk_d = dec(blk_q);
			apc_d = dec(apc_q);
		end
		if (act)
		begin
			open_d = 1'b1;
			ras_d = W'(T_RAS_CK); // [RQ4]
		end
		if (rd)
		begin
			blk_d = rd_blk; // [RQ5]
			if (ap)
			begin
				pend_d = 1'b1;
				apc_d = rd_apd; // [RQ8]
			end
		end
		if (wr)
		begin
			blk_d = wr_blk; // [RQ6]
			if (ap)
			begin
				pend_d = 1'b1;
				apc_d = '0; // [RQ11]
			end
		end
		// Precharge of a closed bank is a no-op and must not restart tRP
		if ((pre && open_q) || fire)
		begin
			open_d = 1'b0;
			pend_d = 1'b0;
			rp_d = W'(T_RP_CK); // [RQ9]
		end
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			open_q <= 1'b0;
			pend_q <= 1'b0;
			ras_q <= '0;
			rp_q <= '0;
			blk_q <= '0;
			apc_q <= '0;
		end
		else if (ce)
		begin
			open_q <= open_d;
			pend_q <= pend_d;
			ras_q <= ras_d;
			rp_q <= rp_d;
			blk_q <= blk_d;
			apc_q <= apc_d;
		end
	end
	AST_BANK_RP_FROM_AP: // [RQ9]
	assert property (@(posedge clk) disable iff (!rst_n)
		(ce && fire) |=> (rp_q == W'(T_RP_CK)) && !open_q && !pend_q)
	else $error("tRP not started at internal precharge");
	AST_BANK_AP_HELD: // [RQ8]
	assert property (@(posedge clk) disable iff (!rst_n)
		(pend_q && ras_q > W'(1)) |-> !fire)
	else $error("auto precharge before tRAS");
endmodule
`default_nettype wire

//--- rtl/dbtr_pkg.sv
// How it works
// [RQ1] Reads interrupt reads only on 4-bit boundaries
// [RQ2] Writes interrupt writes only on 4-bit boundaries
// [RQ3] Read to precharge: AL+BL/2+max(tRTP,2)-2
// [RQ4] Precharge after tRAS, activate after tRP
// [RQ5] tRTP starts AL, or AL+2 for BL8
// [RQ6] Write to precharge: WL+BL/2+tWR
// [RQ7] One mask per byte, write only
// [RQ8] Read auto precharge waits tRAS and tRTP
// [RQ9] tRP counts from internal precharge point
// [RQ10] Reactivate after tRP and tRC
// [RQ11] Write auto precharge after burst plus tWR
// [RQ12] Refresh needs all banks idle tRP
// [RQ13] Internal row counter, tRFC before next
// [RQ14] Refresh gap at most nine tREFI
// [RQ15] Self refresh is refresh with CKE low
// [RQ16] Self refresh: DLL off, refresh, tCKE
// [RQ17] Clock may stop during self refresh
// [RQ18] Only NOP or deselect through tXSNR
// [RQ19] Extra refresh before self refresh again
// [RQ20] No power-down during read or write
// [RQ21] Power-down kind decides DLL and buffers
// [RQ22] CKE low tCKE, at most nine tREFI
// [RQ23] RL is AL plus CL, WL is RL-1
// [RQ24] A10 high precharges all four banks
// [RQ25] Times rounded up to cycles per bank
package dbtr_pkg;
	// Link clock period as seen by the device
	localparam int TCK_NS = 800;
	function automatic int ns2ck(input int ns);
		int c;
		c = (ns + TCK_NS - 1) / TCK_NS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int T_RAS_NS = 45;
	localparam int T_RTP_NS = 8;
	localparam int T_RP_NS = 13;
	localparam int T_WR_NS = 15;
	localparam int T_RFC_NS = 105;
	localparam int T_XSNR_NS = 115;
	localparam int T_REFI_NS = 7800;
	localparam logic [7:0] T_RAS_CK = 8'(ns2ck(T_RAS_NS)); // [RQ25]
	localparam logic [7:0] T_RTP_CK = 8'((ns2ck(T_RTP_NS) > 2) ? ns2ck(T_RTP_NS) : 2);
	localparam logic [7:0] T_RP_CK = 8'(ns2ck(T_RP_NS));
	localparam logic [7:0] T_WR_CK = 8'(ns2ck(T_WR_NS));
	localparam logic [7:0] T_RFC_CK = 8'(ns2ck(T_RFC_NS));
	localparam logic [7:0] T_XSNR_CK = 8'(ns2ck(T_XSNR_NS));
	localparam logic [7:0] T_CKE_CK = 8'h03;
	// Longest time, so rounded down
	localparam logic [15:0] T_REF9_CK = 16'((9 * T_REFI_NS) / TCK_NS);
	localparam int RA_W = 4;
	localparam int DW = 16;
	localparam logic [3:0] REG_CFG = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h4;
	localparam logic [3:0] REG_ERRCLR = 4'h8;
	localparam logic [3:0] REG_ROW = 4'hC;
	localparam int CFG_AL_LSB = 0;
	localparam int CFG_CL_LSB = 3;
	localparam int CFG_BL8_BIT = 7;
	localparam int CFG_FAST_BIT = 8;
	localparam logic [8:0] CFG_RESET = 9'h018;
	localparam logic [3:0] CMD_MRS = 4'h0;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_WR = 4'h4;
	localparam logic [3:0] CMD_RD = 4'h5;
	localparam logic [3:0] CMD_NOP = 4'h7;
	typedef enum logic [1:0] {
		PW_ACTIVE = 2'h0,
		PW_SREF = 2'h1,
		PW_SRX = 2'h3,
		PW_PDOWN = 2'h2
	} dbtr_pwr_t;
endpackage

//--- rtl/dbtr_top.sv
`timescale 1ns/1ns
`default_nettype none
module dbtr_top
(
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	input wire logic CE,
	input wire logic DRAM_CK,
	input wire logic CKE,
	input wire logic CS_N,
	input wire logic RAS_N,
	input wire logic CAS_N,
	input wire logic WE_N,
	input wire logic [1:0] BA,
	input wire logic A10,
	input wire logic [1:0] DM,
	input wire logic [dbtr_pkg::RA_W-1:0] REG_ADDR,
	input wire logic [dbtr_pkg::DW-1:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [dbtr_pkg::DW-1:0] REG_RDATA,
	output logic [3:0] BANK_OPEN,
	output logic [3:0] INT_PRECHARGE,
	output logic INT_REFRESH,
	output logic [12:0] REF_ROW,
	output logic RD_DATA_VALID,
	output logic [1:0] WR_BYTE_EN,
	output logic DLL_EN,
	output logic INBUF_EN,
	output logic PROTO_ERR
);
	import dbtr_pkg::*;
	localparam int PW = 11;
	logic [PW-1:0] s1_q, s2_q;
	logic ck_prev_q, tick, cke_s, a10_s;
	logic [3:0] cmd;
	logic [1:0] ba_s, dm_s;
	// Pins pass two flops; the link clock edge is found on the second stage
	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			s1_q <= '0;
			s2_q <= '0;
			ck_prev_q <= 1'b0;
		end
		else if (CE)
		begin
			s1_q <= {DRAM_CK, CKE, CS_N, RAS_N, CAS_N, WE_N, BA, A10, DM};
			s2_q <= s1_q;
			ck_prev_q <= s2_q[10];
		end
	end
	assign tick = CE && s2_q[10] && !ck_prev_q;
	assign cke_s = s2_q[9];
	assign cmd = s2_q[8:5];
	assign ba_s = s2_q[4:3];
	assign a10_s = s2_q[2];
	assign dm_s = s2_q[1:0];

	logic [8:0] cfg_q, cfg_d;
	logic [DW-1:0] rdata_q, rdata_d;
	dbtr_pwr_t pwr_q, pwr_d;
	logic cke_q, cke_d, pdact_q, pdact_d, rdir_q, rdir_d, rdv_q, rdv_d;
	logic ref_q, ref_d, err_q, err_d, owed_q, owed_d;
	logic [1:0] wbe_q, wbe_d;
	logic [7:0] tmr_q, tmr_d, rfc_q, rfc_d, lat_q, lat_d, beats_q, beats_d, since_q, since_d;
	logic [15:0] gap_q, gap_d;
	logic [12:0] row_q, row_d;
	logic [2:0] al;
	logic [3:0] cl;
	logic bl8, fast;
	logic [7:0] rl, wl, bl2, rd_blk, rd_apd, wr_blk;
	logic live, nop, go_act, go_rd, go_wr, go_pre, go_ref, sr_in, pd_in, viol;
	logic [3:0] sel, act_v, rd_v, wr_v, pre_v, b_open, b_fire, b_act_ok, b_pre_ok;

	assign al = cfg_q[CFG_AL_LSB +: 3];
	assign cl = cfg_q[CFG_CL_LSB +: 4];
	assign bl8 = cfg_q[CFG_BL8_BIT];
	assign fast = cfg_q[CFG_FAST_BIT];
	assign rl = 8'(al) + 8'(cl); // [RQ23]
	assign wl = rl - 8'h01; // [RQ23]
	assign bl2 = bl8 ? 8'h04 : 8'h02;
	assign rd_blk = 8'(al) + (bl8 ? 8'h02 : 8'h00) + T_RTP_CK; // [RQ3] [RQ5]
	assign rd_apd = 8'(al) + bl2; // [RQ8]
	assign wr_blk = wl + bl2 + T_WR_CK; // [RQ6]

	always_comb
	begin
		nop = cmd[3] || cmd == CMD_NOP;
		live = tick && cke_q && cke_s && pwr_q == PW_ACTIVE;
		go_act = live && cmd == CMD_ACT;
		go_rd = live && cmd == CMD_RD;
		go_wr = live && cmd == CMD_WR;
		go_pre = live && cmd == CMD_PRE;
		go_ref = live && cmd == CMD_REF;
		sr_in = tick && cke_q && !cke_s && pwr_q == PW_ACTIVE && cmd == CMD_REF; // [RQ15]
		pd_in = tick && cke_q && !cke_s && pwr_q == PW_ACTIVE && cmd != CMD_REF;
		sel = 4'h1 << ba_s;
		act_v = go_act ? sel : 4'h0;
		rd_v = go_rd ? sel : 4'h0;
		wr_v = go_wr ? sel : 4'h0;
		pre_v = go_pre ? (a10_s ? 4'hF : sel) : 4'h0; // [RQ24]
		viol = (go_act && ((b_act_ok & sel) == 4'h0 || rfc_q > 8'h01)) // [RQ4] [RQ10] [RQ13]
			|| (go_pre && (pre_v & b_open & ~b_pre_ok) != 4'h0) // [RQ3] [RQ6]
			|| ((go_ref || sr_in) && (b_act_ok != 4'hF || rfc_q > 8'h01)) // [RQ12] [RQ13]
			|| ((go_rd || go_wr) && (b_open & sel) == 4'h0)
			|| ((go_rd || go_wr) && (go_rd != rdir_q || since_q[0]) && since_q < bl2) // [RQ1] [RQ2]
			|| (pd_in && (lat_q != 8'h00 || beats_q != 8'h00)) // [RQ20]
			|| (sr_in && owed_q) // [RQ19]
			|| (tick && pwr_q == PW_SRX && !nop) // [RQ18]
			|| (tick && cke_s && tmr_q > 8'h01 && (pwr_q == PW_SREF || pwr_q == PW_PDOWN))
			|| (gap_q > T_REF9_CK); // [RQ14] [RQ22]
		cke_d = tick ? cke_s : cke_q;
		pwr_d = pwr_q;
		pdact_d = pdact_q;
		tmr_d = (tick && tmr_q != 8'h00) ? tmr_q - 8'h01 : tmr_q;
		rfc_d = (tick && rfc_q != 8'h00) ? rfc_q - 8'h01 : rfc_q;
		since_d = (tick && since_q != 8'hFF) ? since_q + 8'h01 : since_q;
		gap_d = (tick && gap_q != 16'hFFFF && pwr_q != PW_SREF) ? gap_q + 16'h0001 : gap_q;
		owed_d = owed_q;
		ref_d = 1'b0;
		row_d = row_q;
		rdv_d = rdv_q;
		wbe_d = wbe_q;
		lat_d = lat_q;
		beats_d = beats_q;
		rdir_d = rdir_q;
		unique case (pwr_q)
			PW_ACTIVE:
			begin
				if (sr_in)
				begin
					pwr_d = PW_SREF; // [RQ15]
					tmr_d = T_CKE_CK; // [RQ16]
				end
				else if (pd_in)
				begin
					pwr_d = PW_PDOWN;
					pdact_d = b_open != 4'h0; // [RQ21]
					tmr_d = T_CKE_CK; // [RQ22]
				end
			end
			PW_SREF:
			begin
				// Clock may stand still here, so only a tick with CKE high leaves
				if (tick && cke_s)
				begin
					pwr_d = PW_SRX; // [RQ17]
					tmr_d = T_XSNR_CK; // [RQ18]
					owed_d = 1'b1; // [RQ19]
				end
			end
			PW_SRX:
			begin
				if (tick && tmr_q == 8'h01)
				begin
					pwr_d = PW_ACTIVE;
				end
			end
			PW_PDOWN:
			begin
				if (tick && cke_s)
				begin
					pwr_d = PW_ACTIVE; // [RQ22]
				end
			end
		endcase
		if (go_ref || sr_in)
		begin
			ref_d = 1'b1; // [RQ13] [RQ16]
			row_d = row_q + 13'h0001;
			rfc_d = T_RFC_CK;
			gap_d = 16'h0001;
			owed_d = 1'b0;
		end
		if (tick)
		begin
			rdv_d = 1'b0;
			wbe_d = 2'h0;
			if (lat_q != 8'h00)
			begin
				lat_d = lat_q - 8'h01;
			end
			else if (beats_q != 8'h00)
			begin
				beats_d = beats_q - 8'h01;
				rdv_d = rdir_q;
				// Mask is sampled like data and has no meaning on reads
				wbe_d = rdir_q ? 2'h0 : ~dm_s; // [RQ7]
			end
			if (go_rd || go_wr)
			begin
				// Counter empties one tick before the first beat
				lat_d = go_rd ? rl - 8'h01 : wl - 8'h01; // [RQ23]
				beats_d = bl2;
				rdir_d = go_rd;
				since_d = 8'h01;
			end
		end
	end

	for (genvar i = 0; i < 4; i++)
	begin : g_bank
		dbtr_bank #(.W(8)) u_bank (
			.clk(CORE_CLK),
			.rst_n(RESET_N),
			.ce(CE),
			.en(tick),
			.act(act_v[i]),
			.rd(rd_v[i]),
			.wr(wr_v[i]),
			.ap(a10_s),
			.pre(pre_v[i]),
			.rd_blk(rd_blk),
			.rd_apd(rd_apd),
			.wr_blk(wr_blk),
			.is_open(b_open[i]),
			.fire(b_fire[i]),
			.act_ok(b_act_ok[i]),
			.pre_ok(b_pre_ok[i])
		);
	end

	always_comb
	begin
		cfg_d = (REG_WR && REG_ADDR == REG_CFG) ? REG_WDATA[8:0] : cfg_q;
		// A new violation wins over a clear in the same cycle
		err_d = viol || (err_q && !(REG_WR && REG_ADDR == REG_ERRCLR && REG_WDATA[0]));
		rdata_d = '0;
		if (REG_RD)
		begin
			unique case (REG_ADDR)
				REG_CFG: rdata_d = DW'(cfg_q);
				REG_STAT: rdata_d = DW'({err_q, DLL_EN, pwr_q, b_open});
				REG_ROW: rdata_d = DW'(row_q);
				default: rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			cfg_q <= CFG_RESET;
			rdata_q <= '0;
			err_q <= 1'b0;
			pwr_q <= PW_ACTIVE;
			cke_q <= 1'b0;
			pdact_q <= 1'b0;
			tmr_q <= 8'h00;
			rfc_q <= 8'h00;
			since_q <= 8'hFF;
			gap_q <= 16'h0000;
			owed_q <= 1'b0;
			ref_q <= 1'b0;
			row_q <= 13'h0000;
			rdv_q <= 1'b0;
			wbe_q <= 2'h0;
			lat_q <= 8'h00;
			beats_q <= 8'h00;
			rdir_q <= 1'b0;
		end
		else if (CE)
		begin
			cfg_q <= cfg_d;
			rdata_q <= rdata_d;
			err_q <= err_d;
			pwr_q <= pwr_d;
			cke_q <= cke_d;
			pdact_q <= pdact_d;
			tmr_q <= tmr_d;
			rfc_q <= rfc_d;
			since_q <= since_d;
			gap_q <= gap_d;
			owed_q <= owed_d;
			ref_q <= ref_d;
			row_q <= row_d;
			rdv_q <= rdv_d;
			wbe_q <= wbe_d;
			lat_q <= lat_d;
			beats_q <= beats_d;
			rdir_q <= rdir_d;
		end
	end

	assign REG_RDATA = rdata_q;
	assign BANK_OPEN = b_open;
	assign INT_PRECHARGE = b_fire;
	assign INT_REFRESH = ref_q;
	assign REF_ROW = row_q;
	assign RD_DATA_VALID = rdv_q;
	assign WR_BYTE_EN = wbe_q;
	assign PROTO_ERR = err_q;
	// Fast-exit active power-down keeps the DLL locked, trading power for exit time
	assign DLL_EN = pwr_q == PW_ACTIVE || pwr_q == PW_SRX || (pwr_q == PW_PDOWN && pdact_q && fast); // [RQ16] [RQ21]
	assign INBUF_EN = pwr_q != PW_PDOWN && pwr_q != PW_SREF; // [RQ21]

	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RESET_N);
	AST_SREF_DLL_OFF: // [RQ16]
	assert property (pwr_q == PW_SREF |-> !DLL_EN && !INBUF_EN)
	else $error("DLL or buffers on in self refresh");
	AST_SREF_REFRESH: // [RQ16]
	assert property (sr_in |=> INT_REFRESH && pwr_q == PW_SREF && tmr_q == T_CKE_CK)
	else $error("no internal refresh at self refresh entry");
	AST_PPD_DLL: // [RQ21]
	assert property ((pd_in && b_open == 4'h0) |=> (pwr_q == PW_PDOWN) && !DLL_EN && !INBUF_EN)
	else $error("precharge power-down left DLL on");
	AST_ROW_STEP: // [RQ13]
	assert property (INT_REFRESH |-> REF_ROW == $past(REF_ROW) + 13'h0001)
	else $error("refresh row counter did not step");
	AST_PRE_ALL: // [RQ24]
	assert property ((go_pre && a10_s) |=> BANK_OPEN == 4'h0)
	else $error("precharge all left a bank open");
	AST_READ_MASK: // [RQ7]
	assert property (RD_DATA_VALID |-> WR_BYTE_EN == 2'h0)
	else $error("byte enables active during read data");
	AST_WRITE_MASK: // [RQ7]
	assert property ((tick && lat_q == 8'h00 && beats_q != 8'h00 && !rdir_q) |=> WR_BYTE_EN == ~$past(dm_s))
	else $error("write mask not applied per byte");
	AST_LATENCY: // [RQ23]
	assert property ((go_wr && CE) |=> lat_q == 8'(al) + 8'(cl) - 8'h02 && !rdir_q && beats_q == bl2)
	else $error("write latency not RL minus one");
	AST_SRX_HOLD: // [RQ18]
	assert property ($rose(pwr_q == PW_SRX) |-> tmr_q == T_XSNR_CK && owed_q)
	else $error("self refresh exit timer not loaded");
	COV_SREF: cover property (pwr_q == PW_SRX ##1 pwr_q == PW_ACTIVE);
	COV_APD_FAST: cover property (pwr_q == PW_PDOWN && DLL_EN);
	COV_AUTO_PRE: cover property (INT_PRECHARGE != 4'h0);
	COV_WR_BEAT: cover property (WR_BYTE_EN == 2'h1);
endmodule
`default_nettype wire
